// ---- core/twsp_host.sv ----
// Host controller driving a sensor's two-wire serial port and power-down pin
`timescale 1ns/100ps
//
// Contract
// - Only the host starts a transaction; the sensor only answers.
// - The host always generates the serial clock.
// - One clock and one shared data line; one driver at a time.
// - Write: address byte with top bit 1, then the data byte.
// - Write data changes on falling clock edges, sampled on rising edges.
// - Read: address byte with top bit 0, sensor returns the data byte.
// - Read: driver changes data on falling edges, receiver samples on rising.
// - Host releases the data line after the last read address bit.
// - Next clock edge after last read address bit waits 100 us or more.
// - After the final read data bit, clock stays high 120 ns or more.
// - No transaction while power-down is high.
// - Power-down high 100 us or more releases the data line after a read.
module twsp_host
    import twsp_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC_DEF,
    parameter int GAP_CYC = READ_GAP_CYC_DEF,
    parameter int PD_CYC = PD_PULSE_CYC_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [DATA_W-1:0] cmd_wdata,
    input wire logic resync_req,
    input wire logic sleep_req,
    output logic busy,
    output logic done,
    output logic rdata_valid,
    output logic [DATA_W-1:0] rdata,
    // Serial pins
    output logic sclk,
    output logic sdio_o,
    output logic sdio_oe,
    input wire logic sdio_i,
    output logic power_down_in
);

    localparam logic [CNT_W-1:0] HALF_LOAD = CNT_W'(HALF_CYC - 1);
    localparam logic [CNT_W-1:0] GAP_LOAD = CNT_W'(GAP_CYC - 1);
    localparam logic [CNT_W-1:0] PD_LOAD = CNT_W'(PD_CYC - 1);
    localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_CYC - 1);
    // Low-phase count below which driving is safe after a read
    localparam logic [CNT_W-1:0] DRV_OK_CNT = CNT_W'(HALF_CYC - HOLD_CYC);

    // Bit counter steps once per serial clock period
    function automatic logic [3:0] bit_next(input logic [3:0] b);
        return b + 4'h1;
    endfunction

    twsp_state_type st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [3:0] bit_q, bit_d;
    logic [FRAME_W-1:0] sh_q, sh_d;
    logic is_wr_q, is_wr_d;
    logic rd_last_q, rd_last_d;
    logic sclk_d;
    logic pd_d;
    logic oe_d;
    logic done_d;
    logic rvalid_d;
    logic [DATA_W-1:0] rdata_d;
    logic sdio_s;

    // Pin input crosses into the clock domain before use
    twsp_sync u_sdio_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in(sdio_i),
        .sync_out(sdio_s)
    );

    wire cnt_zero = (cnt_q == '0);
    wire last_addr = (bit_q == LAST_ADDR_BIT);
    wire last_frame = (bit_q == LAST_FRAME_BIT);
    wire start_ok = cmd_valid && !sleep_req && !resync_req;
    wire [FRAME_W-1:0] frame_in = {cmd_write, cmd_addr, cmd_wdata};
    wire [FRAME_W-1:0] sh_shift = {sh_q[FRAME_W-2:0], 1'h0};
    wire [FRAME_W-1:0] sh_sample = {sh_q[FRAME_W-2:0], sdio_s};
    wire [CNT_W-1:0] cnt_dec = cnt_q - CNT_W'(1);
    wire in_addr_phase = (st_d == ST_LOW) || (st_d == ST_HIGH);
    // After a read the sensor may still drive until it lets go
    wire drv_ok = !rd_last_d || (st_d == ST_HIGH) || (cnt_d < DRV_OK_CNT);
    // Kept out of the state process; built from the st_d, cnt_d and rd_last_d that process writes
    assign oe_d = in_addr_phase && drv_ok;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        bit_d = bit_q;
        sh_d = sh_q;
        is_wr_d = is_wr_q;
        rd_last_d = rd_last_q;
        sclk_d = sclk;
        pd_d = power_down_in;
        done_d = 1'h0;
        rvalid_d = 1'h0;
        rdata_d = rdata;
        case (st_q)
            ST_IDLE: begin
                if (sleep_req || resync_req) begin
                    st_d = ST_PD;
                    pd_d = 1'h1;
                    cnt_d = PD_LOAD;
                end else if (start_ok) begin
                    // Only this side opens a frame
                    st_d = ST_LOW;
                    sclk_d = 1'h0;
                    sh_d = frame_in;
                    is_wr_d = cmd_write;
                    bit_d = FIRST_BIT;
                    cnt_d = HALF_LOAD;
                end
            end
            ST_LOW: begin
                if (cnt_zero) begin
                    st_d = ST_HIGH;
                    sclk_d = 1'h1;
                    rd_last_d = 1'h0;
                    cnt_d = HALF_LOAD;
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            ST_HIGH: begin
                if (!cnt_zero) begin
                    cnt_d = cnt_dec;
                end else if (is_wr_q && last_frame) begin
                    st_d = ST_HOLD;
                    cnt_d = HOLD_LOAD;
                end else if (!is_wr_q && last_addr) begin
                    // Clock held high through the gap
                    st_d = ST_GAP;
                    cnt_d = GAP_LOAD;
                end else begin
                    st_d = ST_LOW;
                    sclk_d = 1'h0;
                    sh_d = sh_shift;
                    bit_d = bit_next(bit_q);
                    cnt_d = HALF_LOAD;
                end
            end
            ST_GAP: begin
                if (cnt_zero) begin
                    st_d = ST_RLOW;
                    sclk_d = 1'h0;
                    bit_d = FIRST_BIT;
                    cnt_d = HALF_LOAD;
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            ST_RLOW: begin
                if (cnt_zero) begin
                    st_d = ST_RHIGH;
                    sclk_d = 1'h1;
                    // Sampled at the rising edge this side makes
                    sh_d = sh_sample;
                    cnt_d = HALF_LOAD;
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            ST_RHIGH: begin
                if (!cnt_zero) begin
                    cnt_d = cnt_dec;
                end else if (last_addr) begin
                    st_d = ST_HOLD;
                    cnt_d = HOLD_LOAD;
                    rd_last_d = 1'h1;
                end else begin
                    st_d = ST_RLOW;
                    sclk_d = 1'h0;
                    bit_d = bit_next(bit_q);
                    cnt_d = HALF_LOAD;
                end
            end
            ST_HOLD: begin
                if (cnt_zero) begin
                    st_d = ST_IDLE;
                    done_d = 1'h1;
                    rvalid_d = !is_wr_q;
                    if (!is_wr_q) begin
                        rdata_d = sh_q[DATA_W-1:0];
                    end
                end else begin
                    cnt_d = cnt_dec;
                end
            end
            ST_PD: begin
                // Sleep lasts at least one full resync pulse
                if (!cnt_zero) begin
                    cnt_d = cnt_dec;
                end else if (!sleep_req) begin
                    st_d = ST_IDLE;
                    pd_d = 1'h0;
                    rd_last_d = 1'h0;
                end
            end
            default: begin
                st_d = ST_IDLE;
                sclk_d = 1'h1;
                pd_d = 1'h0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            bit_q <= FIRST_BIT;
            sh_q <= '0;
            is_wr_q <= DIR_READ;
            rd_last_q <= 1'h0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            is_wr_q <= is_wr_d;
            rd_last_q <= rd_last_d;
        end
    end

    // Pin and status flops; clock idles high
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sclk <= 1'h1;
            sdio_o <= 1'h0;
            sdio_oe <= 1'h0;
            power_down_in <= 1'h0;
            busy <= 1'h0;
            done <= 1'h0;
            rdata_valid <= 1'h0;
            rdata <= '0;
        end else begin
            sclk <= sclk_d;
            sdio_o <= sh_d[FRAME_W-1];
            sdio_oe <= oe_d;
            power_down_in <= pd_d;
            busy <= (st_d != ST_IDLE);
            done <= done_d;
            rdata_valid <= rvalid_d;
            rdata <= rdata_d;
        end
    end

endmodule

// ---- core/twsp_pkg.sv ----
// Constants, timing figures and state codes for the two-wire serial host
package twsp_pkg;

    localparam int CLK_PERIOD_PS = 5000;
    localparam int SCLK_HALF_NS = 160;
    localparam int HOLD_NS = 120;
    localparam int READ_GAP_US = 100;
    localparam int PD_PULSE_US = 100;
    localparam int NS_PER_US = 1000;
    localparam int PS_PER_NS = 1000;

    // Least times round up, never below one cycle
    function automatic int ns_to_cyc(input int ns);
        int cyc;
        cyc = (ns * PS_PER_NS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (cyc < 1) ? 1 : cyc;
    endfunction

    localparam int HOLD_CYC = ns_to_cyc(HOLD_NS);
    localparam int SCLK_HALF_CYC_DEF = ns_to_cyc(SCLK_HALF_NS);
    localparam int READ_GAP_CYC_DEF = ns_to_cyc(READ_GAP_US * NS_PER_US);
    localparam int PD_PULSE_CYC_DEF = ns_to_cyc(PD_PULSE_US * NS_PER_US);

    localparam int CNT_W = 16;
    localparam int FRAME_W = 16;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [3:0] LAST_ADDR_BIT = 4'h7;
    localparam logic [3:0] LAST_FRAME_BIT = 4'hf;
    localparam logic [3:0] FIRST_BIT = 4'h0;
    localparam logic DIR_WRITE = 1'h1;
    localparam logic DIR_READ = 1'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LOW = 3'b001,
        ST_HIGH = 3'b010,
        ST_GAP = 3'b011,
        ST_RLOW = 3'b100,
        ST_RHIGH = 3'b101,
        ST_HOLD = 3'b110,
        ST_PD = 3'b111
    } twsp_state_type;

endpackage

// ---- core/twsp_sync.sv ----
// Two-flop synchroniser for a level arriving from a pin
`timescale 1ns/100ps
module twsp_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Level in and out
    input wire logic async_in,
    output logic sync_out
);

    logic meta_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_q <= 1'h0;
            sync_out <= 1'h0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// ---- tb/twsp_host_bench.sv ----
// Self-checking bench for the two-wire serial host
`timescale 1ns/100ps
module twsp_host_bench;
    import twsp_pkg::*;
    // Short gap and power-down keep the run brief
    localparam int PC = 40;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [ADDR_W-1:0] cmd_addr = 7'h00;
    logic [DATA_W-1:0] cmd_wdata = 8'h00;
    logic resync_req = 1'b0;
    logic sleep_req = 1'b0;
    logic busy, done, rdata_valid, sclk, sdio_o, sdio_oe, power_down_in, drv_o, drv_oe;
    logic [DATA_W-1:0] rdata;
    logic sdio_i;
    int n_errors = 0;
    int total_checks = 0;
    // Undriven line shows the inverse of the last bit
    assign sdio_i = sdio_oe ? sdio_o : (drv_oe ? drv_o : ~drv_o);
    always #2.5 clk = ~clk;
    twsp_host #(.HALF_CYC(32), .GAP_CYC(40), .PD_CYC(PC)) twsp_host_inst (.clk(clk),
        .rstn(rstn), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .resync_req(resync_req), .sleep_req(sleep_req), .busy(busy),
        .done(done), .rdata_valid(rdata_valid), .rdata(rdata), .sclk(sclk), .sdio_o(sdio_o),
        .sdio_oe(sdio_oe), .sdio_i(sdio_i), .power_down_in(power_down_in));
    twsp_sensor twsp_sensor_inst (.sclk(sclk), .sdio(sdio_i), .power_down_in(power_down_in),
        .drv_o(drv_o), .drv_oe(drv_oe));
    task automatic wrap_up();
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Two drivers at once is a bus fight
    always @(posedge clk) begin
        if (sdio_oe === 1'b1 && drv_oe === 1'b1) begin
            n_errors++;
            $display("Error sdio_drivers expected 1 seen 2");
        end
    end
    task automatic wait_while(input logic want);
        int k;
        k = 0;
        while ((want ? power_down_in : busy) === 1'b1 && k < 4000) begin
            @(posedge clk);
            #1;
            k++;
        end
        check("wait_cycles_ok", 8'h01, {7'h00, k >= (want ? PC : 0) && k < 4000});
    endtask
    task automatic run_cmd(input logic w, input logic [6:0] a, input logic [7:0] d);
        int k;
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_addr = a;
        cmd_wdata = d;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 4000) begin
            @(posedge clk);
            #1;
            k++;
        end
        check("rdata_valid", {7'h00, !w}, {7'h00, rdata_valid});
        check("done", 8'h01, {7'h00, done});
        check("busy_at_done", 8'h00, {7'h00, busy});
    endtask
    task automatic t_resync();
        @(posedge clk);
        #1;
        resync_req = 1'b1;
        @(posedge clk);
        #1;
        resync_req = 1'b0;
        wait_while(1'b1);
        check("sensor_oe", 8'h00, {7'h00, drv_oe});
    endtask
    task automatic t_write_read();
        run_cmd(1'b1, 7'h0a, 8'ha5);
        check("reg_0a", 8'ha5, twsp_sensor_inst.mem[10]);
        run_cmd(1'b1, 7'h7f, 8'h3c);
        check("reg_7f", 8'h3c, twsp_sensor_inst.mem[127]);
        run_cmd(1'b0, 7'h0a, 8'h00);
        check("read_0a", 8'ha5, rdata);
        run_cmd(1'b0, 7'h7f, 8'hff);
        check("read_7f", 8'h3c, rdata);
    endtask
    task automatic t_read_write();
        run_cmd(1'b0, 7'h02, 8'h00);
        check("read_motion", 8'h60, rdata);
        run_cmd(1'b1, 7'h05, 8'h81);
        check("reg_05", 8'h81, twsp_sensor_inst.mem[5]);
    endtask
    task automatic t_sleep();
        run_cmd(1'b0, 7'h7f, 8'h00);
        sleep_req = 1'b1;
        repeat (2 * PC) @(posedge clk);
        #1;
        check("pd_level", 8'h01, {7'h00, power_down_in});
        check("sleep_oe", 8'h00, {7'h00, drv_oe});
        sleep_req = 1'b0;
        wait_while(1'b0);
        run_cmd(1'b0, 7'h0a, 8'h00);
        check("kept_0a", 8'ha5, rdata);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_resync();
        t_write_read();
        t_read_write();
        t_sleep();
        wrap_up();
    end
    initial begin
        #300000;
        n_errors++;
        wrap_up();
    end
endmodule
bind twsp_host twsp_sva #(.HALF_CYC(HALF_CYC), .GAP_CYC(GAP_CYC), .PD_CYC(PD_CYC))
    twsp_sva_inst (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .resync_req(resync_req),
    .sleep_req(sleep_req), .busy(busy), .done(done), .rdata_valid(rdata_valid),
    .rdata(rdata), .sclk(sclk), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sdio_i(sdio_i),
    .power_down_in(power_down_in));

// ---- tb/twsp_sensor.sv ----
// Behavioural sensor serial port with register store
`timescale 1ns/100ps
module twsp_sensor #(
    // Transaction timer, longest allowed span
    parameter real SPTT_NS = 700000000.0
) (
    // Serial pins, clock only received
    input wire logic sclk,
    input wire logic sdio,
    input wire logic power_down_in,
    output logic drv_o,
    output logic drv_oe
);
    logic [7:0] mem [128];
    logic [15:0] sh = 16'h0000;
    logic [6:0] ra = 7'h00;
    logic rd = 1'b0;
    int cnt = 0;
    realtime t0 = 0.0;
    initial begin
        drv_o = 1'b0;
        drv_oe = 1'b0;
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i * 3 + 8'h5a);
        end
    end
    // One process owns the port state; power-down wins over clock edges
    always @(posedge power_down_in or posedge sclk or negedge sclk) begin
        if (power_down_in === 1'b1) begin
            // Port state only; the store survives
            cnt = 0;
            rd = 1'b0;
            drv_oe = 1'b0;
        end else if (sclk === 1'b1 && power_down_in === 1'b0) begin
            sh = {sh[14:0], sdio};
            cnt++;
            if (cnt == 8) begin
                rd = ~sh[7];
                ra = sh[6:0];
            end
            if (cnt == 16 && $realtime - t0 > SPTT_NS) begin
                // Late frame is dropped, nothing stored
                cnt = 0;
                rd = 1'b0;
                drv_oe = 1'b0;
            end else if (cnt == 16 && !rd) begin
                mem[sh[14:8]] = sh[7:0];
                cnt = 0;
            end
        end else if (sclk === 1'b0) begin
            // Only ever answers a host read
            if (cnt == 16) begin
                drv_oe = 1'b0;
                cnt = 0;
                rd = 1'b0;
            end else if (rd && cnt >= 8) begin
                drv_oe = 1'b1;
                drv_o = mem[ra][15 - cnt];
            end
            // First clock edge of a frame starts the timer
            if (cnt == 0) begin
                t0 = $realtime;
            end
        end
    end
endmodule

// ---- tb/twsp_sva.sv ----
// Port checker for the two-wire serial host
`timescale 1ns/100ps
module twsp_sva
    import twsp_pkg::*;
#(
    parameter int HALF_CYC = 32,
    parameter int GAP_CYC = 40,
    parameter int PD_CYC = 40
) (
    // Clock, reset, commands
    input wire logic clk,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [DATA_W-1:0] cmd_wdata,
    input wire logic resync_req,
    input wire logic sleep_req,
    // Status
    input wire logic busy,
    input wire logic done,
    input wire logic rdata_valid,
    input wire logic [DATA_W-1:0] rdata,
    // Serial pins
    input wire logic sclk,
    input wire logic sdio_o,
    input wire logic sdio_oe,
    input wire logic sdio_i,
    input wire logic power_down_in
);
    logic [15:0] lo_q, hi_q, pd_q, lo_d, hi_d, pd_d;
    // Run lengths of clock low, clock high, power-down high
    assign lo_d = sclk ? 16'h0000 : lo_q + 16'h0001;
    assign hi_d = sclk ? hi_q + 16'h0001 : 16'h0000;
    assign pd_d = power_down_in ? pd_q + 16'h0001 : 16'h0000;
    always_ff @(posedge clk) begin
        lo_q <= rstn ? lo_d : 16'h0000;
        hi_q <= rstn ? hi_d : 16'h0000;
        pd_q <= rstn ? pd_d : 16'h0000;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_take;
        !busy && !done && cmd_valid && !resync_req && !sleep_req;
    endsequence
    sequence s_release;
        $fell(sdio_oe) && busy;
    endsequence
    a_idle_clock_high: assert property (!busy |-> sclk && !sdio_oe)
        else $error("serial lines active while idle");
    a_cmd_take: assert property (s_take |=> busy && !sclk)
        else $error("command not started");
    a_pd_quiet: assert property (power_down_in |-> sclk && !sdio_oe)
        else $error("traffic during power-down");
    a_data_on_fall: assert property (
        sdio_oe && $past(sdio_oe) && $changed(sdio_o) |-> $fell(sclk))
        else $error("data changed off the falling edge");
    a_low_width: assert property ($rose(sclk) |-> lo_q == HALF_CYC)
        else $error("clock low phase wrong length");
    a_gap_len: assert property (
        $fell(sclk) && !sdio_oe && $past(busy) |-> hi_q == HALF_CYC || hi_q >= GAP_CYC)
        else $error("read gap too short");
    a_release_high: assert property (s_release |-> sclk && hi_q >= HALF_CYC - 1)
        else $error("data line released at wrong point");
    a_hold_done: assert property (done |-> sclk && hi_q >= HOLD_CYC)
        else $error("clock high hold too short");
    a_done_pulse: assert property (done |=> !done && !rdata_valid)
        else $error("done longer than one cycle");
    a_pd_width: assert property ($fell(power_down_in) |-> pd_q >= PD_CYC)
        else $error("power-down pulse too short");
endmodule
